// >>> src/stepper_pkg.sv
// ****************************************************************
// step timing package
// ****************************************************************
package stepper_pkg;

	// ************************************************************
	// register offsets, one byte each
	// ************************************************************
	localparam logic [7:0] ADDR_STEPS_PER_REV_LOW   = 8'h14;
	localparam logic [7:0] ADDR_STEPS_PER_REV_HIGH  = 8'h15;
	localparam logic [7:0] ADDR_FWD_PULSE_WIDTH_LOW  = 8'h16;
	localparam logic [7:0] ADDR_FWD_PULSE_WIDTH_HIGH = 8'h17;
	localparam logic [7:0] ADDR_REV_PULSE_WIDTH_LOW  = 8'h18;
	localparam logic [7:0] ADDR_REV_PULSE_WIDTH_HIGH = 8'h19;
	localparam logic [7:0] ADDR_FWD_STEP_COUNT_LOW   = 8'h1a;
	localparam logic [7:0] ADDR_FWD_STEP_COUNT_HIGH  = 8'h1b;
	localparam logic [7:0] ADDR_REV_STEP_COUNT_LOW   = 8'h1c;
	localparam logic [7:0] ADDR_REV_STEP_COUNT_HIGH  = 8'h1d;
	localparam logic [7:0] ADDR_FWD_REV_COUNT_LOW    = 8'h1e;
	localparam logic [7:0] ADDR_FWD_REV_COUNT_HIGH   = 8'h1f;

	// reset value of every register word
	localparam logic [15:0] REG_RESET = 16'h0000;
	// read value for an offset outside the block
	localparam logic [7:0]  RDATA_UNMAPPED = 8'h00;

	// ************************************************************
	// pulse width word layout
	// ************************************************************
	localparam int unsigned SCALE_MSB  = 15;
	localparam int unsigned SCALE_LSB  = 13;
	localparam int unsigned WIDTH_MSB  = 12;
	localparam logic [12:0] WIDTH_MAX  = 13'h1fff;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int unsigned CLK_HZ       = 25_000_000;
	localparam int unsigned BASE_HZ      = 1_000_000;
	localparam int unsigned CYC_PER_US   = CLK_HZ / BASE_HZ;
	localparam int unsigned MIN_WIDTH_US = 3;
	localparam logic [4:0]  US_DIV_LAST  = 5'(CYC_PER_US - 1);

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		ST_IDLE      = 2'b00,
		ST_RAMP_UP   = 2'b01,
		ST_RUN       = 2'b10,
		ST_RAMP_DOWN = 2'b11
	} motion_e;

	typedef struct packed {
		logic [2:0]  range_scale_code;
		logic [12:0] width;
	} pulse_width_s;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic start;
		logic dir_ccw;
		logic by_rotation;
		logic ramp_up_en;
		logic ramp_down_en;
		logic stop;
	} move_req_s;

	// split a stored word into scale code and width count
	function automatic pulse_width_s split_width(input logic [15:0] word);
		return pulse_width_s'(word);
	endfunction : split_width

endpackage : stepper_pkg

// >>> src/step_time_base.sv
`timescale 1ns/1ps
// ****************************************************************
// microsecond divider and scaled width unit
// ****************************************************************
module step_time_base (
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       srst_i,
	// control
	input  wire logic       run_i,
	input  wire logic [2:0] scale_i,
	// one-cycle unit enable
	output logic            unit_tick_o
);

	logic [4:0] us_cnt_r;      // cycles inside one microsecond
	logic [4:0] us_cnt_nxt;
	logic [9:0] unit_cnt_r;    // microseconds inside one unit
	logic [9:0] unit_cnt_nxt;
	logic       tick_nxt;
	logic [9:0] unit_last;     // 3 us scaled by two to the code, minus one

	// next values; counters sit at zero while stopped so each move
	// starts on a clean unit boundary
	always_comb begin
		unit_last    = 10'((stepper_pkg::MIN_WIDTH_US << scale_i) - 1);
		us_cnt_nxt   = us_cnt_r;
		unit_cnt_nxt = unit_cnt_r;
		tick_nxt     = 1'b0;
		if (!run_i) begin
			us_cnt_nxt   = 5'h00;
			unit_cnt_nxt = 10'h000;
		end else if (us_cnt_r == stepper_pkg::US_DIV_LAST) begin
			us_cnt_nxt = 5'h00;
			if (unit_cnt_r >= unit_last) begin
				unit_cnt_nxt = 10'h000;
				tick_nxt     = 1'b1;
			end else begin
				unit_cnt_nxt = unit_cnt_r + 10'h001;
			end
		end else begin
			us_cnt_nxt = us_cnt_r + 5'h01;
		end
	end

	// registers
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			us_cnt_r    <= 5'h00;
			unit_cnt_r  <= 10'h000;
			unit_tick_o <= 1'b0;
		end else begin
			us_cnt_r    <= us_cnt_nxt;
			unit_cnt_r  <= unit_cnt_nxt;
			unit_tick_o <= tick_nxt;
		end
	end

endmodule : step_time_base

// >>> src/step_period_timer.sv
`timescale 1ns/1ps
// ****************************************************************
// step period counter: width plus one units per step
// ****************************************************************
module step_period_timer (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        srst_i,
	// control
	input  wire logic        run_i,
	input  wire logic        unit_tick_i,
	input  wire logic [12:0] width_i,
	// one-cycle end of step period
	output logic             period_done_o
);

	logic [12:0] cnt_r;     // units elapsed in this period
	logic [12:0] cnt_nxt;
	logic        done_nxt;

	// next values; width is read live so a ramp takes effect next step
	always_comb begin
		cnt_nxt  = cnt_r;
		done_nxt = 1'b0;
		if (!run_i) begin
			cnt_nxt = 13'h0000;
		end else if (unit_tick_i) begin
			if (cnt_r >= width_i) begin
				cnt_nxt  = 13'h0000;
				done_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 13'h0001;
			end
		end
	end

	// registers
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			cnt_r         <= 13'h0000;
			period_done_o <= 1'b0;
		end else begin
			cnt_r         <= cnt_nxt;
			period_done_o <= done_nxt;
		end
	end

endmodule : step_period_timer

// >>> src/step_timing_core.sv
`timescale 1ns/1ps
// ****************************************************************
// step timing core: registers, move length, ramp, step pulses
// ****************************************************************
module step_timing_core (
	// clock and reset
	input  wire logic                    mclk_i,
	input  wire logic                    srst_i,
	// register port from the serial front end
	input  wire stepper_pkg::reg_req_s   reg_req_i,
	output logic [7:0]                   rdata_o,
	// move control from the sequencer
	input  wire stepper_pkg::move_req_s  move_req_i,
	// motion outputs
	output logic                         step_o,
	output logic                         dir_ccw_o,
	output logic                         busy_o,
	output logic                         done_o
);

	// ************************************************************
	// register file
	// ************************************************************
	logic [15:0] spr_r;          // steps per revolution
	logic [15:0] fwd_pw_r;       // forward pulse width word
	logic [15:0] rev_pw_r;       // reverse pulse width word
	logic [15:0] fwd_steps_r;    // forward step count
	logic [15:0] rev_steps_r;    // reverse step count
	logic [15:0] fwd_rots_r;     // forward rotation count
	logic [15:0] spr_nxt;
	logic [15:0] fwd_pw_nxt;
	logic [15:0] rev_pw_nxt;
	logic [15:0] fwd_steps_nxt;
	logic [15:0] rev_steps_nxt;
	logic [15:0] fwd_rots_nxt;
	logic [7:0]  rdata_nxt;

	// byte write into one half of a word
	function automatic logic [15:0] put_byte(input logic [15:0] word,
		input logic high, input logic [7:0] data);
		return high ? {data, word[7:0]} : {word[15:8], data};
	endfunction : put_byte

	// write decode and read mux
	always_comb begin
		spr_nxt       = spr_r;
		fwd_pw_nxt    = fwd_pw_r;
		rev_pw_nxt    = rev_pw_r;
		fwd_steps_nxt = fwd_steps_r;
		rev_steps_nxt = rev_steps_r;
		fwd_rots_nxt  = fwd_rots_r;
		if (reg_req_i.wr) begin
			unique case (reg_req_i.addr)
				stepper_pkg::ADDR_STEPS_PER_REV_LOW,
				stepper_pkg::ADDR_STEPS_PER_REV_HIGH: begin
					spr_nxt = put_byte(spr_r, reg_req_i.addr[0], reg_req_i.wdata);
				end
				stepper_pkg::ADDR_FWD_PULSE_WIDTH_LOW,
				stepper_pkg::ADDR_FWD_PULSE_WIDTH_HIGH: begin
					fwd_pw_nxt = put_byte(fwd_pw_r, reg_req_i.addr[0], reg_req_i.wdata);
				end
				stepper_pkg::ADDR_REV_PULSE_WIDTH_LOW,
				stepper_pkg::ADDR_REV_PULSE_WIDTH_HIGH: begin
					rev_pw_nxt = put_byte(rev_pw_r, reg_req_i.addr[0], reg_req_i.wdata);
				end
				stepper_pkg::ADDR_FWD_STEP_COUNT_LOW,
				stepper_pkg::ADDR_FWD_STEP_COUNT_HIGH: begin
					fwd_steps_nxt = put_byte(fwd_steps_r, reg_req_i.addr[0], reg_req_i.wdata);
				end
				stepper_pkg::ADDR_REV_STEP_COUNT_LOW,
				stepper_pkg::ADDR_REV_STEP_COUNT_HIGH: begin
					rev_steps_nxt = put_byte(rev_steps_r, reg_req_i.addr[0], reg_req_i.wdata);
				end
				stepper_pkg::ADDR_FWD_REV_COUNT_LOW,
				stepper_pkg::ADDR_FWD_REV_COUNT_HIGH: begin
					fwd_rots_nxt = put_byte(fwd_rots_r, reg_req_i.addr[0], reg_req_i.wdata);
				end
				// other offsets belong to other blocks: writes ignored
				default: begin
				end
			endcase
		end
		// read data held until the next read
		rdata_nxt = rdata_o;
		if (reg_req_i.rd) begin
			unique case (reg_req_i.addr)
				stepper_pkg::ADDR_STEPS_PER_REV_LOW:    rdata_nxt = spr_r[7:0];
				stepper_pkg::ADDR_STEPS_PER_REV_HIGH:   rdata_nxt = spr_r[15:8];
				stepper_pkg::ADDR_FWD_PULSE_WIDTH_LOW:  rdata_nxt = fwd_pw_r[7:0];
				stepper_pkg::ADDR_FWD_PULSE_WIDTH_HIGH: rdata_nxt = fwd_pw_r[15:8];
				stepper_pkg::ADDR_REV_PULSE_WIDTH_LOW:  rdata_nxt = rev_pw_r[7:0];
				stepper_pkg::ADDR_REV_PULSE_WIDTH_HIGH: rdata_nxt = rev_pw_r[15:8];
				stepper_pkg::ADDR_FWD_STEP_COUNT_LOW:   rdata_nxt = fwd_steps_r[7:0];
				stepper_pkg::ADDR_FWD_STEP_COUNT_HIGH:  rdata_nxt = fwd_steps_r[15:8];
				stepper_pkg::ADDR_REV_STEP_COUNT_LOW:   rdata_nxt = rev_steps_r[7:0];
				stepper_pkg::ADDR_REV_STEP_COUNT_HIGH:  rdata_nxt = rev_steps_r[15:8];
				stepper_pkg::ADDR_FWD_REV_COUNT_LOW:    rdata_nxt = fwd_rots_r[7:0];
				stepper_pkg::ADDR_FWD_REV_COUNT_HIGH:   rdata_nxt = fwd_rots_r[15:8];
				default:                                rdata_nxt = stepper_pkg::RDATA_UNMAPPED;
			endcase
		end
	end

	// register storage, all words clear on reset
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			spr_r       <= stepper_pkg::REG_RESET;
			fwd_pw_r    <= stepper_pkg::REG_RESET;
			rev_pw_r    <= stepper_pkg::REG_RESET;
			fwd_steps_r <= stepper_pkg::REG_RESET;
			rev_steps_r <= stepper_pkg::REG_RESET;
			fwd_rots_r  <= stepper_pkg::REG_RESET;
			rdata_o     <= 8'h00;
		end else begin
			spr_r       <= spr_nxt;
			fwd_pw_r    <= fwd_pw_nxt;
			rev_pw_r    <= rev_pw_nxt;
			fwd_steps_r <= fwd_steps_nxt;
			rev_steps_r <= rev_steps_nxt;
			fwd_rots_r  <= fwd_rots_nxt;
			rdata_o     <= rdata_nxt;
		end
	end

	// ************************************************************
	// motion control
	// ************************************************************
	stepper_pkg::motion_e      state_r;      // motion phase
	stepper_pkg::motion_e      state_nxt;
	logic [31:0]               remain_r;     // steps left in this move
	logic [31:0]               remain_nxt;
	logic [12:0]               width_r;      // width count in use now
	logic [12:0]               width_nxt;
	logic [2:0]                scale_r;      // scale code of this move
	logic [2:0]                scale_nxt;
	logic                      ramp_dn_r;    // ramp down allowed this move
	logic                      ramp_dn_nxt;
	logic                      dir_nxt;
	logic                      done_nxt;
	stepper_pkg::pulse_width_s sel_pw;       // word for requested direction
	stepper_pkg::pulse_width_s run_pw;       // word for running direction
	logic [31:0]               move_len;     // steps requested
	logic                      unit_tick;
	logic                      period_done;
	logic                      running;

	assign running = (state_r != stepper_pkg::ST_IDLE);

	// divider to the scaled width unit
	step_time_base u_time_base (
		.mclk_i      (mclk_i),
		.srst_i      (srst_i),
		.run_i       (running),
		.scale_i     (scale_r),
		.unit_tick_o (unit_tick)
	);

	// counts width plus one units per step
	step_period_timer u_period (
		.mclk_i        (mclk_i),
		.srst_i        (srst_i),
		.run_i         (running),
		.unit_tick_i   (unit_tick),
		.width_i       (width_r),
		.period_done_o (period_done)
	);

	// move sequencing; a stop request outranks the end of a move
	always_comb begin
		// rotation moves run forward, so they take the forward word too
		sel_pw = stepper_pkg::split_width(
			(move_req_i.dir_ccw && !move_req_i.by_rotation) ? rev_pw_r : fwd_pw_r);
		run_pw = stepper_pkg::split_width(dir_ccw_o ? rev_pw_r : fwd_pw_r);
		// rotation moves run forward; the product is only meaningful once
		// the host has set a nonzero steps per revolution
		if (move_req_i.by_rotation) begin
			move_len = 32'(fwd_rots_r) * 32'(spr_r);
		end else if (move_req_i.dir_ccw) begin
			move_len = 32'(rev_steps_r);
		end else begin
			move_len = 32'(fwd_steps_r);
		end
		state_nxt   = state_r;
		remain_nxt  = remain_r;
		width_nxt   = width_r;
		scale_nxt   = scale_r;
		ramp_dn_nxt = ramp_dn_r;
		dir_nxt     = dir_ccw_o;
		done_nxt    = 1'b0;
		unique case (state_r)
			stepper_pkg::ST_IDLE: begin
				if (move_req_i.start) begin
					dir_nxt     = move_req_i.dir_ccw & ~move_req_i.by_rotation;
					scale_nxt   = sel_pw.range_scale_code;
					remain_nxt  = move_len;
					ramp_dn_nxt = move_req_i.ramp_down_en;
					if (move_len == 32'h0000_0000) begin
						done_nxt = 1'b1; // empty move ends at once
					end else if (move_req_i.ramp_up_en) begin
						width_nxt = stepper_pkg::WIDTH_MAX;
						state_nxt = stepper_pkg::ST_RAMP_UP;
					end else begin
						width_nxt = sel_pw.width;
						state_nxt = stepper_pkg::ST_RUN;
					end
				end
			end
			stepper_pkg::ST_RAMP_UP, stepper_pkg::ST_RUN: begin
				if (move_req_i.stop) begin
					if (ramp_dn_r) begin
						state_nxt = stepper_pkg::ST_RAMP_DOWN;
					end else begin
						state_nxt = stepper_pkg::ST_IDLE;
						done_nxt  = 1'b1;
					end
				end else if (period_done) begin
					remain_nxt = remain_r - 32'h0000_0001;
					if (remain_r == 32'h0000_0001) begin
						state_nxt = stepper_pkg::ST_IDLE;
						done_nxt  = 1'b1;
					end else if (state_r == stepper_pkg::ST_RAMP_UP) begin
						// one count faster per step until the target
						if ({1'b0, width_r} > {1'b0, run_pw.width} + 14'h0001) begin
							width_nxt = width_r - 13'h0001;
						end else begin
							width_nxt = run_pw.width;
							state_nxt = stepper_pkg::ST_RUN;
						end
					end else begin
						width_nxt = run_pw.width;
					end
				end
			end
			stepper_pkg::ST_RAMP_DOWN: begin
				if (period_done) begin
					remain_nxt = remain_r - 32'h0000_0001;
					if (width_r == stepper_pkg::WIDTH_MAX ||
						remain_r == 32'h0000_0001) begin
						state_nxt = stepper_pkg::ST_IDLE;
						done_nxt  = 1'b1;
					end else begin
						width_nxt = width_r + 13'h0001;
					end
				end
			end
		endcase
	end

	// motion registers; outputs come straight from flops
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			state_r   <= stepper_pkg::ST_IDLE;
			remain_r  <= 32'h0000_0000;
			width_r   <= 13'h0000;
			scale_r   <= 3'h0;
			ramp_dn_r <= 1'b0;
			dir_ccw_o <= 1'b0;
			done_o    <= 1'b0;
			busy_o    <= 1'b0;
			step_o    <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			remain_r  <= remain_nxt;
			width_r   <= width_nxt;
			scale_r   <= scale_nxt;
			ramp_dn_r <= ramp_dn_nxt;
			dir_ccw_o <= dir_nxt;
			done_o    <= done_nxt;
			busy_o    <= (state_nxt != stepper_pkg::ST_IDLE);
			step_o    <= period_done & running;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	logic [31:0] gap_cnt_r;    // cycles since the last step period end
	logic        steady_r;     // a full period has run at steady width
	logic [31:0] expect_gap;   // cycles per step at the running width

	always_comb begin
		expect_gap = 32'(stepper_pkg::CYC_PER_US * stepper_pkg::MIN_WIDTH_US)
			* (32'h1 << scale_r) * (32'(width_r) + 32'h1);
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			gap_cnt_r <= 32'h0;
			steady_r  <= 1'b0;
		end else begin
			gap_cnt_r <= period_done ? 32'h0 : gap_cnt_r + 32'h1;
			steady_r  <= (state_r == stepper_pkg::ST_RUN) &&
				(period_done || steady_r) && (width_nxt == width_r);
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	sequence s_stop_taken;
		running && move_req_i.stop && ramp_dn_r;
	endsequence

	sequence s_down_at_max;
		(state_r == stepper_pkg::ST_RAMP_DOWN) && period_done &&
			(width_r == stepper_pkg::WIDTH_MAX);
	endsequence

	reset_clears_a: assert property (@(posedge mclk_i) disable iff (1'b0)
		srst_i |=> (spr_r == 16'h0 && fwd_steps_r == 16'h0 && fwd_rots_r == 16'h0))
		else $error("registers not cleared by reset");
	spr_write_a: assert property (
		reg_req_i.wr && reg_req_i.addr == stepper_pkg::ADDR_STEPS_PER_REV_HIGH
		|=> spr_r[15:8] == $past(reg_req_i.wdata))
		else $error("steps per revolution high byte not stored");
	fwd_width_a: assert property (
		reg_req_i.wr && reg_req_i.addr == stepper_pkg::ADDR_FWD_PULSE_WIDTH_LOW
		|=> fwd_pw_r[7:0] == $past(reg_req_i.wdata) && $stable(fwd_pw_r[15:8]))
		else $error("forward width low byte not stored");
	rev_scale_a: assert property (
		!running && move_req_i.start && move_req_i.dir_ccw && !move_req_i.by_rotation
		|=> scale_r == $past(rev_pw_r[15:13]))
		else $error("reverse scale code not taken from bits 15:13");
	step_len_a: assert property (
		!running && move_req_i.start && !move_req_i.by_rotation && !move_req_i.dir_ccw
		|=> remain_r == 32'($past(fwd_steps_r)))
		else $error("forward move length wrong");
	rot_len_a: assert property (
		!running && move_req_i.start && move_req_i.by_rotation
		|=> remain_r == $past(32'(fwd_rots_r) * 32'(spr_r)) && !dir_ccw_o)
		else $error("rotation move length wrong");
	ramp_start_a: assert property (
		!running && move_req_i.start && move_req_i.ramp_up_en && move_len != 32'h0
		|=> state_r == stepper_pkg::ST_RAMP_UP && width_r == stepper_pkg::WIDTH_MAX)
		else $error("ramp does not start at range maximum");
	ramp_dec_a: assert property (
		state_r == stepper_pkg::ST_RAMP_UP && period_done && !move_req_i.stop &&
		remain_r > 32'h1 && {1'b0, width_r} > {1'b0, run_pw.width} + 14'h0001
		|=> width_r == $past(width_r) - 13'h1)
		else $error("acceleration did not step the width down");
	ramp_end_a: assert property (s_down_at_max |=> !busy_o && done_o)
		else $error("deceleration did not end at range maximum");
	decel_entry_a: assert property (s_stop_taken |=>
		state_r == stepper_pkg::ST_RAMP_DOWN || done_o)
		else $error("stop with ramp down did not decelerate");
	step_period_a: assert property (
		period_done && steady_r && state_r == stepper_pkg::ST_RUN
		|-> gap_cnt_r + 32'h1 == expect_gap)
		else $error("step period differs from unit times width plus one");

endmodule : step_timing_core

// >>> sim/host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// host side: byte writes and reads on the register port
// ****************************************************************
module host_model (
	// clock
	input  wire logic                  mclk_i,
	// register port toward the block
	output stepper_pkg::reg_req_s      req_o,
	input  wire logic [7:0]            rdata_i
);
	// idle bus at time zero, no strobe
	initial req_o = '0;

	// one byte written, strobe held for exactly one edge
	task automatic wr_byte(input logic [7:0] addr, input logic [7:0] data);
		@(posedge mclk_i);
		req_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
		@(posedge mclk_i);
		// released lines show inverted leftovers so stale data never matches
		req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
	endtask : wr_byte

	// one byte read, data taken once it has settled
	task automatic rd_byte(input logic [7:0] addr, output logic [7:0] data);
		@(posedge mclk_i);
		req_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
		@(posedge mclk_i);
		req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hff};
		@(negedge mclk_i);
		data = rdata_i;
	endtask : rd_byte
endmodule : host_model

// >>> sim/stepper_step_timing_and_counts_tb.sv
`timescale 1ns/1ps
// ****************************************************************
// step timing bench
// ****************************************************************
module stepper_step_timing_and_counts_tb;
	logic                      mclk_i;    // 25 MHz clock
	logic                      srst_i;    // sync reset
	stepper_pkg::reg_req_s     req;       // from host model
	stepper_pkg::move_req_s    mv;        // move control
	logic [7:0]                rdata;     // read byte
	logic                      step_o;    // step pulse
	logic                      dir_ccw_o; // direction
	logic                      busy_o;    // move running
	logic                      done_o;    // move ended
	int                        errors;    // mismatches
	int                        cmp_count; // comparisons

	// clock, 40 ns period
	initial mclk_i = 1'b0;
	always #20 mclk_i = ~mclk_i;

	host_model host (.mclk_i(mclk_i), .req_o(req), .rdata_i(rdata));

	step_timing_core dut (
		.mclk_i(mclk_i), .srst_i(srst_i), .reg_req_i(req), .rdata_o(rdata),
		.move_req_i(mv), .step_o(step_o), .dir_ccw_o(dir_ccw_o),
		.busy_o(busy_o), .done_o(done_o)
	);

	// single comparison point, four-state exact
	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// verdict and end of run
	task automatic final_report();
		if (errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report

	// expected cycles between steps: 25 cycles per us, 3 us unit
	function automatic int gap_of(input int code, input int w);
		return stepper_pkg::CYC_PER_US * stepper_pkg::MIN_WIDTH_US * (1 << code) * (w + 1);
	endfunction : gap_of

	// a 16-bit word as two bytes, low at the even offset
	task automatic set_word(input logic [7:0] addr, input logic [15:0] val);
		host.wr_byte(addr, val[7:0]);
		host.wr_byte(addr + 8'h01, val[15:8]);
	endtask : set_word

	// ************************************************************
	// register reset values, readback, unmapped read
	// ************************************************************
	task automatic test_regs();
		logic [7:0] d;
		for (int a = 8'h14; a <= 8'h1f; a++) begin
			host.rd_byte(8'(a), d);
			chk("reg reset", d, 8'h00);
		end
		// distinct byte per offset catches swapped or aliased bytes
		for (int a = 8'h14; a <= 8'h1f; a++) host.wr_byte(8'(a), 8'(a) ^ 8'ha5);
		for (int a = 8'h14; a <= 8'h1f; a++) begin
			host.rd_byte(8'(a), d);
			chk("reg readback", d, 8'(a) ^ 8'ha5);
		end
		host.rd_byte(8'h20, d);
		chk("unmapped", d, stepper_pkg::RDATA_UNMAPPED);
	endtask : test_regs

	// ************************************************************
	// one move: step count, last spacing, end state
	// ************************************************************
	task automatic run_move(input logic ccw, input logic rot, input int n_exp, input int gap_exp,
		input logic rdn = 1'b0, input int stop_at = 0);
		int cyc;
		int last;
		int gap;
		int n;
		cyc = 0;
		last = 0;
		gap = 0;
		n = 0;
		@(posedge mclk_i);
		mv <= '{start: 1'b1, dir_ccw: ccw, by_rotation: rot,
			ramp_up_en: 1'b0, ramp_down_en: rdn, stop: 1'b0};
		@(posedge mclk_i);
		mv.start <= 1'b0;
		// bounded wait for the end pulse
		while (cyc < 20000) begin
			@(negedge mclk_i);
			cyc++;
			if (step_o === 1'b1) begin
				gap = cyc - last;
				last = cyc;
				n++;
				if (n == stop_at) begin
					// one-edge stop pulse; the skipped falling edge is counted
					@(posedge mclk_i);
					mv.stop <= 1'b1;
					@(posedge mclk_i);
					mv.stop <= 1'b0;
					cyc++;
				end
			end
			if (done_o === 1'b1) break;
		end
		// a wait that ran out shows no end pulse here
		chk("move ended", done_o, 1'b1);
		chk("step count", n, n_exp);
		if (n > 1) chk("step gap", gap, gap_exp);
		chk("direction", dir_ccw_o, ccw);
		@(negedge mclk_i);
		chk("busy after", busy_o, 1'b0);
	endtask : run_move

	// ************************************************************
	// moves over several scale codes and widths
	// ************************************************************
	task automatic test_moves();
		set_word(stepper_pkg::ADDR_FWD_PULSE_WIDTH_LOW, 16'h0000);
		set_word(stepper_pkg::ADDR_FWD_STEP_COUNT_LOW, 16'h0002);
		run_move(1'b0, 1'b0, 2, gap_of(0, 0));
		set_word(stepper_pkg::ADDR_REV_PULSE_WIDTH_LOW, 16'h2001);
		set_word(stepper_pkg::ADDR_REV_STEP_COUNT_LOW, 16'h0003);
		run_move(1'b1, 1'b0, 3, gap_of(1, 1));
		// top scale code, largest unit
		set_word(stepper_pkg::ADDR_FWD_PULSE_WIDTH_LOW, 16'he000);
		run_move(1'b0, 1'b0, 2, gap_of(7, 0));
		// zero length ends at once
		set_word(stepper_pkg::ADDR_REV_STEP_COUNT_LOW, 16'h0000);
		run_move(1'b1, 1'b0, 0, 0);
		// nonzero steps per revolution before a rotation move
		set_word(stepper_pkg::ADDR_STEPS_PER_REV_LOW, 16'h0003);
		set_word(stepper_pkg::ADDR_FWD_REV_COUNT_LOW, 16'h0002);
		set_word(stepper_pkg::ADDR_FWD_PULSE_WIDTH_LOW, 16'h0002);
		run_move(1'b0, 1'b1, 6, gap_of(0, 2));
	endtask : test_moves

	// ************************************************************
	// ramps: slow start, plain stop, stop by deceleration
	// ************************************************************
	task automatic test_ramps();
		int n;
		n = 0;
		set_word(stepper_pkg::ADDR_FWD_STEP_COUNT_LOW, 16'h0003);
		@(posedge mclk_i);
		mv <= '{start: 1'b1, dir_ccw: 1'b0, by_rotation: 1'b0,
			ramp_up_en: 1'b1, ramp_down_en: 1'b0, stop: 1'b0};
		@(posedge mclk_i);
		mv.start <= 1'b0;
		// width 2 would step after 225 cycles; a ramp start must be slower
		repeat (300) begin
			@(negedge mclk_i);
			if (step_o !== 1'b0) n++;
		end
		chk("ramp start slow", n, 0);
		chk("ramp busy", busy_o, 1'b1);
		@(posedge mclk_i);
		mv.stop <= 1'b1;
		@(posedge mclk_i);
		mv.stop <= 1'b0;
		@(negedge mclk_i);
		chk("plain stop", {busy_o, done_o}, 2'b01);
		// stop after the first step: width grows by one, count ends it
		set_word(stepper_pkg::ADDR_FWD_PULSE_WIDTH_LOW, 16'h0000);
		run_move(1'b0, 1'b0, 3, gap_of(0, 1), 1'b1, 1);
	endtask : test_ramps

	// main sequence
	initial begin
		errors = 0;
		cmp_count = 0;
		srst_i = 1'b1;
		mv = '0;
		repeat (20) @(posedge mclk_i);
		srst_i <= 1'b0;
		test_regs();
		test_moves();
		test_ramps();
		final_report();
	end

	// watchdog, well past the expected run length
	initial begin
		repeat (60000) @(posedge mclk_i);
		errors++;
		final_report();
	end
endmodule : stepper_step_timing_and_counts_tb
